/* File: testbench/dsl_ctrl_bench.sv */
// self-checking bench for the serial load control block
`timescale 1ns/1ps
module dsl_ctrl_bench;
    import dsl_pkg::*;
    logic clk_sys, reset_n, frame_select_n, serial_clk, serial_data_in;
    logic serial_data_out, output_load_strobe_n, clear_to_preset_n;
    logic pin_reset_n, dac_update, sdo_oe, oe_seen;
    logic [DSL_DATA_W-1:0] dac_level;
    logic [23:0] rd;
    int error_cnt = 0, checks = 0, upd = 0, cyc = 0, u0;

    dsl_ctrl i_dsl_ctrl (.clk_sys(clk_sys), .reset_n(reset_n),
        .frame_select_n(frame_select_n), .serial_clk(serial_clk),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .serial_data_out_oe(sdo_oe),
        .output_load_strobe_n(output_load_strobe_n),
        .clear_to_preset_n(clear_to_preset_n), .pin_reset_n(pin_reset_n),
        .dac_level(dac_level), .dac_update(dac_update));
    dsl_host i_dsl_host (.clk_sys(clk_sys), .frame_select_n(frame_select_n),
        .serial_clk(serial_clk), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // sampled away from the launching edge to avoid a race with the design
    always @(negedge clk_sys) begin
        cyc <= cyc + 1;
        if (dac_update === 1'b1) upd <= upd + 1;
        if (sdo_oe === 1'b1) oe_seen <= 1'b1;
    end

    // whole run needs about 2700 cycles
    always @(negedge clk_sys) if (cyc == 10000) begin
        error_cnt++;
        $display("ERROR %0t run did not complete", $time);
        finish_test();
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    task automatic chk20(input logic [19:0] got, input logic [19:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t level %h expected %h", $time, got, exp);
        end
    endtask : chk20

    task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk24

    // write one word, then let the converter side settle
    task automatic wr(input logic [2:0] a, input logic [19:0] d);
        i_dsl_host.xfer({1'b0, a, d}, 24, rd);
        i_dsl_host.wait_n(3);
    endtask : wr

    task automatic rdback(input logic [2:0] a, input logic [19:0] d);
        i_dsl_host.xfer({1'b1, a, 20'h00000}, 24, rd);
        i_dsl_host.xfer(24'h800000, 24, rd);
        chk24(rd, {1'b1, a, d});
    endtask : rdback

    task automatic s_load();
        u0 = upd;
        wr(DSL_ADDR_CODE, 20'h12345);
        chk20(dac_level, 20'h12345);
        chk20(20'(upd - u0), 20'h00001);
        output_load_strobe_n = 1'b1;
        u0 = upd;
        wr(DSL_ADDR_CODE, 20'habcde);
        chk20(dac_level, 20'h12345);
        chk20(20'(upd - u0), 20'h00000);
        output_load_strobe_n = 1'b0;
        i_dsl_host.wait_n(6);
        chk20(dac_level, 20'habcde);
        chk20(20'(upd - u0), 20'h00001);
    endtask : s_load

    task automatic s_clear();
        wr(DSL_ADDR_CLEAR, 20'h00005);
        clear_to_preset_n = 1'b0;
        i_dsl_host.wait_n(6);
        chk20(dac_level, 20'h00005);
        clear_to_preset_n = 1'b1;
        wr(DSL_ADDR_CTRL, 20'h00002);
        clear_to_preset_n = 1'b0;
        i_dsl_host.wait_n(6);
        chk20(dac_level, 20'h80005);
        clear_to_preset_n = 1'b1;
        wr(DSL_ADDR_CTRL, 20'h00000);
    endtask : s_clear

    task automatic s_refuse();
        wr(DSL_ADDR_CODE, 20'h5a5a5);
        rdback(DSL_ADDR_CODE, 20'h5a5a5);
        i_dsl_host.xfer({1'b0, DSL_ADDR_CODE, 20'h11111}, 23, rd);
        i_dsl_host.wait_n(3);
        chk20(dac_level, 20'h5a5a5);
        i_dsl_host.stray(5);
        chk20(dac_level, 20'h5a5a5);
        chk20({19'h00000, sdo_oe}, 20'h00000);
        chk20({19'h00000, oe_seen}, 20'h00001);
        wr(DSL_ADDR_CODE, 20'h22222);
        chk20(dac_level, 20'h22222);
    endtask : s_refuse

    task automatic s_pin_reset();
        wr(DSL_ADDR_CLEAR, 20'h0f0f0);
        pin_reset_n = 1'b0;
        i_dsl_host.wait_n(6);
        pin_reset_n = 1'b1;
        i_dsl_host.wait_n(4);
        chk20(dac_level, DSL_CODE_RST);
        rdback(DSL_ADDR_CLEAR, DSL_CLEAR_RST);
    endtask : s_pin_reset

    initial begin
        reset_n = 1'b0;
        oe_seen = 1'b0;
        output_load_strobe_n = 1'b0;
        clear_to_preset_n = 1'b1;
        pin_reset_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        reset_n = 1'b1;
        i_dsl_host.wait_n(4);
        chk20(dac_level, DSL_CODE_RST);
        s_load();
        s_clear();
        s_refuse();
        s_pin_reset();
        finish_test();
    end
endmodule : dsl_ctrl_bench

/* File: testbench/dsl_host.sv */
// host serial port model driving the link pins
`timescale 1ns/1ps
module dsl_host (
    // clock
    input wire logic clk_sys,
    // link pins
    output logic frame_select_n,
    output logic serial_clk,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    initial begin
        frame_select_n = 1'b1;
        serial_clk = 1'b1;
        serial_data_in = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_n

    // 80 ns link period keeps below both the write and the readback limit
    task automatic xfer(input logic [23:0] w, input int n,
                        output logic [23:0] rd);
        rd = 24'h000000;
        frame_select_n = 1'b0;
        serial_data_in = w[23];
        wait_n(4);
        for (int i = 23; i > 23 - n; i--) begin
            serial_clk = 1'b0;
            wait_n(4);
            serial_clk = 1'b1;
            if (i > 0) serial_data_in = w[i-1];
            wait_n(4);
            rd[i] = serial_data_out;
        end
        frame_select_n = 1'b1;
        // released data line flips so a stale level is never trusted
        serial_data_in = ~serial_data_in;
        wait_n(4);
    endtask : xfer

    // clock edges with no frame open
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            serial_clk = 1'b0;
            wait_n(4);
            serial_clk = 1'b1;
            wait_n(4);
        end
    endtask : stray
endmodule : dsl_host

/* File: verilog/dsl_ctrl.sv */
// serial word receiver and output update control
`timescale 1ns/1ps
module dsl_ctrl
    import dsl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // serial link pins
    input wire logic frame_select_n,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    // control pins
    input wire logic output_load_strobe_n,
    input wire logic clear_to_preset_n,
    input wire logic pin_reset_n,
    // converter side
    output logic [dsl_pkg::DSL_DATA_W-1:0] dac_level,
    output logic dac_update
);
    import dsl_pkg::*;

    logic [5:0] pins_s;
    logic fs_n_s, sck_s, sdi_s, load_n_s, clr_n_s, prst_n_s;

    // host clock is slow against clk_sys (80 ns vs 10 ns), so it is sampled
    dsl_sync #(.WIDTH(6), .RST_VAL(6'h3f)) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in({frame_select_n, serial_clk, serial_data_in,
                   output_load_strobe_n, clear_to_preset_n, pin_reset_n}),
        .sync_out(pins_s)
    );
    assign {fs_n_s, sck_s, sdi_s, load_n_s, clr_n_s, prst_n_s} = pins_s;

    logic fs_n_d_r, fs_n_d_nxt, sck_d_r, sck_d_nxt, load_n_d_r, load_n_d_nxt;
    logic [DSL_WORD_W-1:0] shift_r, shift_nxt, rb_shift_r, rb_shift_nxt;
    logic [DSL_WORD_W-1:0] rb_word_r, rb_word_nxt;
    logic [DSL_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [DSL_DATA_W-1:0] in_reg_r, in_reg_nxt, code_r, code_nxt;
    logic [DSL_DATA_W-1:0] ctrl_r, ctrl_nxt, clr_val_r, clr_val_nxt;
    logic [DSL_DATA_W-1:0] level_r, level_nxt;
    logic sdo_r, sdo_nxt, upd_r, upd_nxt;
    logic sck_fall, sck_rise, fs_fall, fs_rise, load_fall, in_frame;
    logic word_ok, is_read;
    logic [DSL_ADDR_W-1:0] word_addr;
    logic [DSL_DATA_W-1:0] word_data, rb_data;

    function automatic logic [DSL_DATA_W-1:0] dsl_code_map(
        input logic [DSL_DATA_W-1:0] code,
        input logic twos
    );
        // twos complement maps onto offset binary by flipping the sign bit
        dsl_code_map = twos ? {~code[DSL_DATA_W-1], code[DSL_DATA_W-2:0]}
                            : code;
    endfunction : dsl_code_map

    assign in_frame = !fs_n_s;
    assign sck_fall = sck_d_r && !sck_s;
    assign sck_rise = !sck_d_r && sck_s;
    assign fs_fall = fs_n_d_r && !fs_n_s;
    assign fs_rise = !fs_n_d_r && fs_n_s;
    assign load_fall = load_n_d_r && !load_n_s;
    assign word_ok = (cnt_r == DSL_BITS_PER_WORD);
    assign is_read = shift_r[DSL_RW_POS];
    assign word_addr = shift_r[DSL_ADDR_HI:DSL_ADDR_LO];
    assign word_data = shift_r[DSL_DATA_W-1:0];

    always_comb begin
        unique case (word_addr)
            DSL_ADDR_CODE: rb_data = code_r;
            DSL_ADDR_CTRL: rb_data = ctrl_r;
            DSL_ADDR_CLEAR: rb_data = clr_val_r;
            default: rb_data = '0;
        endcase
    end

    always_comb begin
        fs_n_d_nxt = fs_n_s;
        sck_d_nxt = sck_s;
        load_n_d_nxt = load_n_s;
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        rb_word_nxt = rb_word_r;
        rb_shift_nxt = rb_shift_r;
        sdo_nxt = sdo_r;
        in_reg_nxt = in_reg_r;
        code_nxt = code_r;
        ctrl_nxt = ctrl_r;
        clr_val_nxt = clr_val_r;
        upd_nxt = 1'b0;
        if (fs_fall) begin
            cnt_nxt = '0;
            rb_shift_nxt = rb_word_r;
            sdo_nxt = 1'b0;
        end else if (in_frame && sck_fall) begin
            // bits past 24 push the oldest bits out; the word is then refused
            shift_nxt = {shift_r[DSL_WORD_W-2:0], sdi_s};
            if (cnt_r != 5'h1f) begin
                cnt_nxt = cnt_r + 5'h01;
            end
        end else if (in_frame && sck_rise) begin
            sdo_nxt = rb_shift_r[DSL_WORD_W-1];
            rb_shift_nxt = {rb_shift_r[DSL_WORD_W-2:0], 1'b0};
        end
        if (fs_rise && word_ok) begin
            if (is_read) begin
                rb_word_nxt = {1'b1, word_addr, rb_data};
            end else begin
                unique case (word_addr)
                    DSL_ADDR_CODE: begin
                        in_reg_nxt = word_data;
                        if (!load_n_s) begin
                            code_nxt = word_data;
                            upd_nxt = 1'b1;
                        end
                    end
                    DSL_ADDR_CTRL: ctrl_nxt = word_data;
                    DSL_ADDR_CLEAR: clr_val_nxt = word_data;
                    default: ;
                endcase
            end
        end
        if (load_fall) begin
            code_nxt = in_reg_r;
            upd_nxt = 1'b1;
        end
        if (!clr_n_s) begin
            code_nxt = clr_val_r;
            upd_nxt = 1'b1;
        end
        if (!prst_n_s) begin
            // pin reset is a synchronous return to power-on state
            shift_nxt = DSL_WORD_RST;
            cnt_nxt = '0;
            rb_word_nxt = DSL_WORD_RST;
            rb_shift_nxt = DSL_WORD_RST;
            sdo_nxt = 1'b0;
            in_reg_nxt = DSL_CODE_RST;
            code_nxt = DSL_CODE_RST;
            ctrl_nxt = DSL_CTRL_RST;
            clr_val_nxt = DSL_CLEAR_RST;
            upd_nxt = 1'b0;
        end
        level_nxt = dsl_code_map(code_nxt, ctrl_nxt[DSL_CTRL_TWOS_POS]);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fs_n_d_r <= 1'b1;
            sck_d_r <= 1'b1;
            load_n_d_r <= 1'b1;
            shift_r <= DSL_WORD_RST;
            cnt_r <= '0;
            rb_word_r <= DSL_WORD_RST;
            rb_shift_r <= DSL_WORD_RST;
            sdo_r <= 1'b0;
            in_reg_r <= DSL_CODE_RST;
            code_r <= DSL_CODE_RST;
            ctrl_r <= DSL_CTRL_RST;
            clr_val_r <= DSL_CLEAR_RST;
            level_r <= DSL_CODE_RST;
            upd_r <= 1'b0;
        end else begin
            fs_n_d_r <= fs_n_d_nxt;
            sck_d_r <= sck_d_nxt;
            load_n_d_r <= load_n_d_nxt;
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            rb_word_r <= rb_word_nxt;
            rb_shift_r <= rb_shift_nxt;
            sdo_r <= sdo_nxt;
            in_reg_r <= in_reg_nxt;
            code_r <= code_nxt;
            ctrl_r <= ctrl_nxt;
            clr_val_r <= clr_val_nxt;
            level_r <= level_nxt;
            upd_r <= upd_nxt;
        end
    end

    assign serial_data_out = sdo_r;
    assign serial_data_out_oe = in_frame;
    assign dac_level = level_r;
    assign dac_update = upd_r;

    default clocking dsl_cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_word_end;
        fs_rise && word_ok && !is_read && word_addr == DSL_ADDR_CODE
            && clr_n_s && prst_n_s && !load_fall;
    endsequence

    property p_idle_edges;
        !in_frame && !fs_rise && prst_n_s && clr_n_s && !load_fall
            |=> $stable(shift_r) && $stable(cnt_r) && $stable(code_r);
    endproperty
    a_idle_edges: assert property (p_idle_edges)
        else $error("state moved outside a frame");

    property p_shift_in;
        in_frame && !fs_fall && sck_fall && prst_n_s && cnt_r < 5'h18
            |=> cnt_r == $past(cnt_r) + 5'h01
                && shift_r[0] == $past(sdi_s);
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("falling clock edge did not shift a bit in");

    property p_load_low;
        s_word_end and !load_n_s |=> code_r == $past(word_data) && upd_r;
    endproperty
    a_load_low: assert property (p_load_low)
        else $error("frame end with load low did not update output");

    property p_load_high;
        s_word_end and load_n_s |=> $stable(code_r)
            && in_reg_r == $past(word_data);
    endproperty
    a_load_high: assert property (p_load_high)
        else $error("frame end with load high changed the output");

    property p_load_fall;
        load_fall && clr_n_s && prst_n_s |=> code_r == $past(in_reg_r);
    endproperty
    a_load_fall: assert property (p_load_fall)
        else $error("load falling edge did not transfer input register");

    property p_clear;
        !clr_n_s && prst_n_s |=> code_r == $past(clr_val_r) && upd_r;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not load the clear value");

    property p_pin_reset;
        !prst_n_s |=> code_r == DSL_CODE_RST && ctrl_r == DSL_CTRL_RST
            && cnt_r == '0 && !upd_r;
    endproperty
    a_pin_reset: assert property (p_pin_reset)
        else $error("pin reset left state behind");

    property p_shift_out;
        in_frame && sck_rise && !fs_fall && prst_n_s
            |=> sdo_r == $past(rb_shift_r[DSL_WORD_W-1]);
    endproperty
    a_shift_out: assert property (p_shift_out)
        else $error("readback bit not driven on rising clock");

    property p_coding;
        ##1 $changed(code_r) || $changed(ctrl_r)
            |-> level_r == dsl_code_map(code_r, ctrl_r[DSL_CTRL_TWOS_POS]);
    endproperty
    a_coding: assert property (p_coding)
        else $error("output level does not follow the coding");

    property p_oe;
        fs_fall |-> serial_data_out_oe [*2];
    endproperty
    a_oe: assert property (p_oe)
        else $error("output not enabled inside frame");
endmodule : dsl_ctrl

/* File: verilog/dsl_pkg.sv */
// constants shared by the serial load control block
package dsl_pkg;
    // word format: read flag, address, data, sent msb first
    localparam int DSL_WORD_W = 24;
    localparam int DSL_DATA_W = 20;
    localparam int DSL_ADDR_W = 3;
    localparam int DSL_RW_POS = 23;
    localparam int DSL_ADDR_HI = 22;
    localparam int DSL_ADDR_LO = 20;
    localparam int DSL_CNT_W = 5;
    localparam logic [DSL_CNT_W-1:0] DSL_BITS_PER_WORD = 5'h18;

    // internal register addresses
    localparam logic [DSL_ADDR_W-1:0] DSL_ADDR_CODE = 3'h1;
    localparam logic [DSL_ADDR_W-1:0] DSL_ADDR_CTRL = 3'h2;
    localparam logic [DSL_ADDR_W-1:0] DSL_ADDR_CLEAR = 3'h3;

    // control register fields
    localparam int DSL_CTRL_TWOS_POS = 1;

    // power-on values
    localparam logic [DSL_DATA_W-1:0] DSL_CODE_RST = 20'h00000;
    localparam logic [DSL_DATA_W-1:0] DSL_CTRL_RST = 20'h00000;
    localparam logic [DSL_DATA_W-1:0] DSL_CLEAR_RST = 20'h00000;
    localparam logic [DSL_WORD_W-1:0] DSL_WORD_RST = 24'h000000;

    // host-side serial clock limits and synchroniser depth, kept for reference; neither the bench nor the logic reads them
    localparam int DSL_SCLK_WRITE_MAX_MHZ = 35;
    localparam int DSL_SCLK_READ_MAX_MHZ = 16;
    localparam int DSL_SYNC_STAGES = 2;
endpackage : dsl_pkg

/* File: verilog/dsl_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module dsl_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // pins and synchronised levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    // meta_r feeds only sync_r
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule : dsl_sync
